// *** src/pllcls_pkg.sv ***
package pllcls_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 24;
	localparam logic [23:0] CTRL_OFS = 24'hc3_0000;
	localparam logic [23:0] STAT_OFS = 24'hc3_0002;
	localparam logic [23:0] TEST_OFS = 24'hc3_0003;
	localparam logic [23:0] TEST2_OFS = 24'hc3_0004;

	// Control register fields and reset value (multiplier 4x, divide 2)
	localparam int MFD_LSB = 12;
	localparam int RFD_LSB = 8;
	localparam int CLOCK_LOSS_DETECT_ENABLE_BIT = 7;
	localparam int FAST_WAKEUP_BIT = 5;
	localparam int STOP_MODE_SELECT_LSB = 2;
	localparam logic [2:0] MFD_RESET = 3'h2;
	localparam logic [2:0] RFD_RESET = 3'h1;
	localparam logic CLOCK_LOSS_DETECT_ENABLE_RESET = 1'h0;
	localparam logic FAST_WAKEUP_RESET = 1'h0;
	localparam logic [1:0] STOP_MODE_SELECT_RESET = 2'h0;

	// Status register fields
	localparam int ST_MODE_BIT = 7;
	localparam int ST_SEL_BIT = 6;
	localparam int ST_REF_BIT = 5;
	localparam int ST_STICKY_LOCK_FLAG_BIT = 4;
	localparam int ST_LOCK_BIT = 3;
	localparam int ST_STICKY_CLOCK_LOSS_FLAG_BIT = 2;

	// Factory test registers
	localparam int SPARE_W = 10;
	localparam logic [9:0] SPARE_RESET = 10'h000;
	localparam logic [7:0] TEST_READ = 8'h00;

	// ----------------------------------------------------------------
	// Clock modes as {mode, ratio select, reference source}
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_EXT = 3'h0;
	localparam logic [2:0] MODE_ONE = 3'h4;
	localparam logic [2:0] MODE_NORM_EXT = 3'h6;
	localparam logic [2:0] MODE_NORM_CRYSTAL_INPUT_PIN = 3'h7;
	localparam logic [1:0] STOP_MODE_SELECT_ALL_OFF = 2'h3;
	localparam int STOP_MODE_SELECT_PLL_OFF_BIT = 1;

	// ----------------------------------------------------------------
	// Timing and tolerance
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int LOSS_TIME_NS = 1000;
	localparam int LOSS_CYC = (LOSS_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int SETTLE_CYC = 4;
	localparam int LOCK_WINDOW = 64;
	localparam int TOL_SCALE = 10000;
	localparam int LOCK_TOL = 75;
	localparam int UNLOCK_TOL = 150;
	localparam int MFD_OFFSET = 2;

	// Pin sampler lanes
	localparam int PIN_REF = 0;
	localparam int PIN_FB = 1;
	localparam int PIN_OSC = 2;
	localparam int PIN_PLL_ENABLE_STRAP = 3;
	localparam int PIN_SEL = 4;
	localparam int PIN_PREF = 5;
	localparam int NPIN = 6;

	typedef enum logic [1:0] {
		ST_RESET,
		ST_RUN,
		ST_STOP
	} pllcls_state_t;

endpackage : pllcls_pkg

// *** src/pllcls_status.sv ***
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
// Contract
// - Lock loss clears sticky lock until reset or a multiplier change.
// - PLL disabled in stop keeps sticky lock at its pre-stop value.
// - With fast wakeup, sticky lock reads clear after a stop with the PLL off until relock.
// - Flag reads taken as the condition changes may show the old value.
// - After reset sticky lock is clear in external mode, set in PLL modes.
// - Lock flag set when frequency is within about 0.75 percent.
// - Lock flag clears on a deviation above about 1.5 percent.
// - Reset release waits for the lock flag in PLL modes.
// - External clock mode keeps the lock flag clear after reset.
// - PLL modes set and hold sticky clock loss on reference or PLL failure.
// - Full-stop fast wakeup: self-clocked, loss flag set until osc ready.
// - Clock loss detected only when enabled or oscillator still recovering.
// - Sticky clock loss always reads zero in external clock mode.
// - Byte test register reads zero; writes ignored without error.
// - Wide test register bits 31 to 10 read zero and ignore writes.
// - Ten spare bits store writes, readable anytime, reset to zero.
// - Clock source strap captured during reset, ignored afterwards.
// - Strap change during reset forces immediate loss of lock.
// - Normal mode ratio is multiplier plus two over two to the divider.
// - External clock mode divides the clock by two.
// - Mode bits encode 000 external, 100 one-to-one, 110/111 normal.
// - Sticky lock set on lock after reset or multiplier-changing write.
module pllcls_status
	import pllcls_pkg::*;
#(
	parameter int WINDOW = LOCK_WINDOW,
	parameter int LOSS_CYCLES = LOSS_CYC
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic ref_clk_pin,
	input wire logic pll_fb_pin,
	input wire logic osc_ready_pin,
	input wire logic pll_enable_strap,
	input wire logic pll_ratio_strap,
	input wire logic pll_ref_strap,
	input wire logic stop_req,
	output logic sys_reset_n_out,
	output logic lock_flag,
	output logic self_clocked_mode,
	output logic [3:0] sys_mult,
	output logic [3:0] sys_div_shift
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic is_ext(input logic [2:0] mode);
		is_ext = (mode == MODE_EXT);
	endfunction : is_ext

	// Encode straps into a legal mode code
	function automatic logic [2:0] enc_mode(input logic en, input logic sel,
		input logic pref);
		if (!en) begin
			enc_mode = MODE_EXT;
		end else if (!sel) begin
			enc_mode = MODE_ONE;
		end else begin
			enc_mode = pref ? MODE_NORM_CRYSTAL_INPUT_PIN : MODE_NORM_EXT;
		end
	endfunction : enc_mode

	// ----------------------------------------------------------------
	// Pin samplers
	// ----------------------------------------------------------------
	logic [NPIN-1:0] s1_ff;
	logic [NPIN-1:0] s2_ff;
	logic [NPIN-1:0] s3_ff;
	logic [NPIN-1:0] filt_ff;
	logic [NPIN-1:0] agree;
	logic [NPIN-1:0] pins;

	assign pins = {pll_ref_strap, pll_ratio_strap, pll_enable_strap,
		osc_ready_pin, pll_fb_pin, ref_clk_pin};
	assign agree = ~(s2_ff ^ s3_ff);

	// A change counts only once the last two stages agree
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			filt_ff <= '0;
		end else begin
			s1_ff <= pins;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			filt_ff <= (agree & s3_ff) | (~agree & filt_ff);
		end
	end

	logic ref_prev_ff;
	logic fb_prev_ff;
	logic ref_edge;
	logic fb_edge;

	// Rising edges of the monitored clocks
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ref_prev_ff <= 1'b0;
			fb_prev_ff <= 1'b0;
		end else begin
			ref_prev_ff <= filt_ff[PIN_REF];
			fb_prev_ff <= filt_ff[PIN_FB];
		end
	end
	assign ref_edge = filt_ff[PIN_REF] & ~ref_prev_ff;
	assign fb_edge = filt_ff[PIN_FB] & ~fb_prev_ff;

	// ----------------------------------------------------------------
	// Control register and test registers
	// ----------------------------------------------------------------
	logic [2:0] mfd_ff;
	logic [2:0] rfd_ff;
	logic clock_loss_detect_enable_ff;
	logic fast_wakeup_ff;
	logic [1:0] stop_mode_select_ff;
	logic [SPARE_W-1:0] spare_ff;
	logic wr_ctrl;
	logic mfd_change;

	assign wr_ctrl = reg_wr && (reg_addr == CTRL_OFS);
	assign mfd_change = wr_ctrl && (reg_wdata[MFD_LSB+:3] != mfd_ff);

	// Control fields; status and byte test writes fall through unused
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mfd_ff <= MFD_RESET;
			rfd_ff <= RFD_RESET;
			clock_loss_detect_enable_ff <= CLOCK_LOSS_DETECT_ENABLE_RESET;
			fast_wakeup_ff <= FAST_WAKEUP_RESET;
			stop_mode_select_ff <= STOP_MODE_SELECT_RESET;
		end else if (wr_ctrl) begin
			mfd_ff <= reg_wdata[MFD_LSB+:3];
			rfd_ff <= reg_wdata[RFD_LSB+:3];
			clock_loss_detect_enable_ff <= reg_wdata[CLOCK_LOSS_DETECT_ENABLE_BIT];
			fast_wakeup_ff <= reg_wdata[FAST_WAKEUP_BIT];
			stop_mode_select_ff <= reg_wdata[STOP_MODE_SELECT_LSB+:2];
		end
	end

	// Spare bits store writes; upper bits have no storage
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			spare_ff <= SPARE_RESET;
		end else if (reg_wr && (reg_addr == TEST2_OFS)) begin
			spare_ff <= reg_wdata[SPARE_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Reset phase, strap capture and stop sequencing
	// ----------------------------------------------------------------
	pllcls_state_t state_ff;
	logic [2:0] mode_ff;
	logic [2:0] settle_ff;
	logic settled;
	logic strap_change;
	logic ext;
	logic lock_ff;
	logic stop_pll_off_ff;
	logic stop_all_off_ff;
	logic pending_ff;
	logic recover_ff;

	assign settled = (settle_ff == 3'(SETTLE_CYC));
	assign ext = is_ext(mode_ff);
	assign strap_change = (state_ff == ST_RESET) && settled &&
		(enc_mode(filt_ff[PIN_PLL_ENABLE_STRAP], filt_ff[PIN_SEL], filt_ff[PIN_PREF])
		!= mode_ff);

	// Straps are sampled on every edge of the reset phase, frozen after
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff <= MODE_EXT;
			settle_ff <= 3'h0;
		end else if (state_ff == ST_RESET) begin
			mode_ff <= enc_mode(filt_ff[PIN_PLL_ENABLE_STRAP], filt_ff[PIN_SEL],
				filt_ff[PIN_PREF]);
			if (!settled) begin
				settle_ff <= settle_ff + 3'h1;
			end
		end
	end

	// Reset phase ends on lock, or once the straps settle in external mode
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_RESET;
		end else begin
			case (state_ff)
				ST_RESET: begin
					if (settled && !strap_change && (ext || lock_ff)) begin
						state_ff <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (stop_req) begin
						state_ff <= ST_STOP;
					end
				end
				ST_STOP: begin
					if (!stop_req) begin
						state_ff <= ST_RUN;
					end
				end
				default: begin
					state_ff <= ST_RESET;
				end
			endcase
		end
	end

	// Stop bookkeeping; fast wakeup is meaningless in external mode
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stop_pll_off_ff <= 1'b0;
			stop_all_off_ff <= 1'b0;
			pending_ff <= 1'b0;
			recover_ff <= 1'b0;
		end else begin
			if (state_ff == ST_RUN && stop_req) begin
				stop_pll_off_ff <= stop_mode_select_ff[STOP_MODE_SELECT_PLL_OFF_BIT] && !ext;
				stop_all_off_ff <= (stop_mode_select_ff == STOP_MODE_SELECT_ALL_OFF) && !ext;
			end
			if (state_ff == ST_STOP && !stop_req && fast_wakeup_ff) begin
				pending_ff <= stop_pll_off_ff;
				recover_ff <= stop_all_off_ff;
			end else begin
				if (lock_ff) begin
					pending_ff <= 1'b0;
				end
				if (filt_ff[PIN_OSC]) begin
					recover_ff <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Frequency lock detector
	// ----------------------------------------------------------------
	logic [15:0] ref_cnt_ff;
	logic [15:0] fb_cnt_ff;
	logic [3:0] ratio;
	logic [31:0] fb_total;
	logic [31:0] expect_cnt;
	logic [31:0] diff;
	logic window_end;
	logic in_tight;
	logic out_loose;
	logic restart;

	// Feedback runs at the multiplied rate before the output divider
	assign ratio = (mode_ff == MODE_ONE) ? 4'h1 :
		4'({1'b0, mfd_ff} + 4'(MFD_OFFSET));
	assign fb_total = 32'(fb_cnt_ff) + 32'(fb_edge);
	assign expect_cnt = 32'(WINDOW) * 32'(ratio);
	assign diff = (fb_total > expect_cnt) ? fb_total - expect_cnt :
		expect_cnt - fb_total;
	assign window_end = ref_edge && (ref_cnt_ff == 16'(WINDOW - 1));
	assign in_tight = diff * 32'(TOL_SCALE) <= expect_cnt * 32'(LOCK_TOL);
	assign out_loose = diff * 32'(TOL_SCALE) > expect_cnt * 32'(UNLOCK_TOL);
	assign restart = ext || mfd_change || strap_change ||
		(state_ff == ST_STOP && stop_pll_off_ff);

	// Count both clocks over a window of reference edges
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ref_cnt_ff <= 16'h0;
			fb_cnt_ff <= 16'h0;
		end else if (restart || window_end) begin
			ref_cnt_ff <= 16'h0;
			fb_cnt_ff <= 16'h0;
		end else begin
			if (ref_edge) begin
				ref_cnt_ff <= ref_cnt_ff + 16'h1;
			end
			if (fb_edge && fb_cnt_ff != 16'hffff) begin
				fb_cnt_ff <= fb_cnt_ff + 16'h1;
			end
		end
	end

	// Tight window to gain lock, loose window to lose it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lock_ff <= 1'b0;
		end else if (restart) begin
			lock_ff <= 1'b0;
		end else if (window_end) begin
			lock_ff <= lock_ff ? !out_loose : in_tight;
		end
	end

	// ----------------------------------------------------------------
	// Sticky lock
	// ----------------------------------------------------------------
	logic sticky_lock_flag_ff;
	logic arm_ff;
	logic lock_rise;
	logic lock_loss;

	assign lock_rise = !restart && window_end && !lock_ff && in_tight;
	assign lock_loss = (!restart && window_end && lock_ff && out_loose) ||
		strap_change;

	// Stop with the PLL off is not a loss, so the flag is left alone
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sticky_lock_flag_ff <= 1'b0;
			arm_ff <= 1'b1;
		end else if (mfd_change) begin
			sticky_lock_flag_ff <= 1'b0;
			arm_ff <= 1'b1;
		end else if (lock_loss) begin
			sticky_lock_flag_ff <= 1'b0;
		end else if (lock_rise && arm_ff) begin
			sticky_lock_flag_ff <= 1'b1;
			arm_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Clock loss monitor
	// ----------------------------------------------------------------
	logic [15:0] ref_idle_ff;
	logic [15:0] fb_idle_ff;
	logic ref_lost;
	logic fb_lost;
	logic watch;
	logic sticky_clock_loss_flag_ff;
	logic scm_ref_ff;

	assign ref_lost = (ref_idle_ff == 16'(LOSS_CYCLES));
	assign fb_lost = (fb_idle_ff == 16'(LOSS_CYCLES));
	assign watch = (state_ff == ST_RUN) && !ext &&
		(clock_loss_detect_enable_ff || recover_ff);

	// Idle counters restart in stop so a wakeup is not a false loss
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ref_idle_ff <= 16'h0;
			fb_idle_ff <= 16'h0;
		end else begin
			if (ref_edge || state_ff == ST_STOP) begin
				ref_idle_ff <= 16'h0;
			end else if (!ref_lost) begin
				ref_idle_ff <= ref_idle_ff + 16'h1;
			end
			if (fb_edge || state_ff == ST_STOP) begin
				fb_idle_ff <= 16'h0;
			end else if (!fb_lost) begin
				fb_idle_ff <= fb_idle_ff + 16'h1;
			end
		end
	end

	// Held until reset; reference failure also forces self-clocked mode
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sticky_clock_loss_flag_ff <= 1'b0;
			scm_ref_ff <= 1'b0;
		end else if (watch) begin
			if (ref_lost || fb_lost) begin
				sticky_clock_loss_flag_ff <= 1'b1;
			end
			if (ref_lost) begin
				scm_ref_ff <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs and frequency relation
	// ----------------------------------------------------------------
	logic [3:0] mult_ff;
	logic [3:0] shift_ff;
	logic rst_out_ff;
	logic scm_ff;
	logic lock_out_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mult_ff <= 4'h1;
			shift_ff <= 4'h1;
			rst_out_ff <= 1'b0;
			scm_ff <= 1'b0;
			lock_out_ff <= 1'b0;
		end else begin
			if (ext) begin
				mult_ff <= 4'h1;
				shift_ff <= 4'h1;
			end else if (mode_ff == MODE_ONE) begin
				mult_ff <= 4'h1;
				shift_ff <= 4'h0;
			end else begin
				mult_ff <= ratio;
				shift_ff <= {1'b0, rfd_ff};
			end
			rst_out_ff <= (state_ff != ST_RESET);
			scm_ff <= scm_ref_ff || recover_ff;
			lock_out_ff <= lock_ff;
		end
	end

	assign sys_mult = mult_ff;
	assign sys_div_shift = shift_ff;
	assign sys_reset_n_out = rst_out_ff;
	assign self_clocked_mode = scm_ff;
	assign lock_flag = lock_out_ff;

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic [7:0] status;

	// Fast wakeup masks sticky lock; loss reads zero in external mode
	always_comb begin
		status = 8'h00;
		status[ST_MODE_BIT] = mode_ff[2];
		status[ST_SEL_BIT] = mode_ff[1];
		status[ST_REF_BIT] = mode_ff[0];
		status[ST_STICKY_LOCK_FLAG_BIT] = sticky_lock_flag_ff && !pending_ff;
		status[ST_LOCK_BIT] = lock_ff;
		status[ST_STICKY_CLOCK_LOSS_FLAG_BIT] = !ext && (sticky_clock_loss_flag_ff || recover_ff);
	end

	// Flags sampled at the strobe edge, so a same-edge change is missed
	always_comb begin
		nxt_rdata = 32'h0;
		case (reg_addr)
			CTRL_OFS: begin
				nxt_rdata[MFD_LSB+:3] = mfd_ff;
				nxt_rdata[RFD_LSB+:3] = rfd_ff;
				nxt_rdata[CLOCK_LOSS_DETECT_ENABLE_BIT] = clock_loss_detect_enable_ff;
				nxt_rdata[FAST_WAKEUP_BIT] = fast_wakeup_ff;
				nxt_rdata[STOP_MODE_SELECT_LSB+:2] = stop_mode_select_ff;
			end
			STAT_OFS: begin
				nxt_rdata[7:0] = status;
			end
			TEST_OFS: begin
				nxt_rdata[7:0] = TEST_READ;
			end
			TEST2_OFS: begin
				nxt_rdata[SPARE_W-1:0] = spare_ff;
			end
			default: begin
				nxt_rdata = 32'h0;
			end
		endcase
	end

	// Data stands only in the cycle after the read strobe
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= 32'h0;
		end else begin
			rdata_ff <= reg_rd ? nxt_rdata : 32'h0;
		end
	end
	assign reg_rdata = rdata_ff;

endmodule : pllcls_status

// *** testbench/pllcls_status_props.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker for the synthesizer status block
// ------------------------------------------------------------
module pllcls_status_props
	import pllcls_pkg::*;
#(
	parameter int WINDOW = LOCK_WINDOW,
	parameter int LOSS_CYCLES = LOSS_CYC
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic pll_enable_strap,
	input wire logic sys_reset_n_out,
	input wire logic lock_flag,
	input wire logic [3:0] sys_mult,
	input wire logic [3:0] sys_div_shift
);
	logic [3:0] exp_mult_ff;
	logic [3:0] exp_shift_ff;
	logic ext_rel;

	// Ratio expected from the last control write
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			exp_mult_ff <= 4'h4;
			exp_shift_ff <= 4'h1;
		end else if (reg_wr && reg_addr == CTRL_OFS) begin
			exp_mult_ff <= {1'b0, reg_wdata[MFD_LSB +: 3]} + 4'h2;
			exp_shift_ff <= {1'b0, reg_wdata[RFD_LSB +: 3]};
		end
	end

	// Strap low alone is not enough: it may move after release
	assign ext_rel = sys_reset_n_out && !pll_enable_strap &&
		sys_mult == 4'h1 && sys_div_shift == 4'h1;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_stat_rd;
		reg_rd && reg_addr == STAT_OFS;
	endsequence

	sequence s_ratio_wr;
		reg_wr && reg_addr == CTRL_OFS && sys_mult != 4'h1;
	endsequence

	a_test_zero:
		assert property (reg_rd && reg_addr == TEST_OFS |=>
			reg_rdata == 32'h0)
		else $error("Byte test register read nonzero");
	a_wide_upper_zero:
		assert property (reg_rd && reg_addr == TEST2_OFS |=>
			reg_rdata[31:SPARE_W] == 22'h0)
		else $error("Wide test register upper bits nonzero");
	a_ext_lock_clear:
		assert property (ext_rel |-> !lock_flag)
		else $error("Lock flag set in external clock mode");
	a_ext_status_clear:
		assert property (s_stat_rd ##0 ext_rel |=>
			!reg_rdata[ST_STICKY_LOCK_FLAG_BIT] && !reg_rdata[ST_STICKY_CLOCK_LOSS_FLAG_BIT])
		else $error("Sticky flags set in external clock mode");
	a_release_locked:
		assert property ($rose(sys_reset_n_out) && pll_enable_strap |->
			##[0:1] lock_flag)
		else $error("Reset released without lock");
	a_release_holds:
		assert property (sys_reset_n_out |=> sys_reset_n_out)
		else $error("System reset reasserted");
	a_strap_ignored:
		assert property (sys_reset_n_out && $changed(pll_enable_strap)
			|=> $stable(sys_mult)[*4])
		else $error("Ratio moved on strap change after release");
	a_ratio_follows:
		assert property (s_ratio_wr |-> ##[1:3]
			(sys_mult == exp_mult_ff && sys_div_shift == exp_shift_ff))
		else $error("Ratio does not follow control write");
endmodule : pllcls_status_props

bind pllcls_status pllcls_status_props #(
	.WINDOW(WINDOW),
	.LOSS_CYCLES(LOSS_CYCLES)
) u_props (
	.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .pll_enable_strap(pll_enable_strap),
	.sys_reset_n_out(sys_reset_n_out), .lock_flag(lock_flag),
	.sys_mult(sys_mult), .sys_div_shift(sys_div_shift)
);

// *** testbench/pllcls_ref_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Reference, feedback and oscillator seen at the pins
// ------------------------------------------------------------
module pllcls_ref_model #(
	parameter int REF_HALF = 24,
	parameter int OSC_START = 20
) (
	input wire logic clock,
	input wire logic ref_run,
	input wire logic [7:0] fb_half,
	input wire logic osc_on,
	output logic ref_clk_pin,
	output logic pll_fb_pin,
	output logic osc_ready_pin
);
	int ref_cnt_ff = 0;
	int fb_cnt_ff = 0;
	int osc_cnt_ff = 0;
	logic ref_ff = 1'b0;
	logic fb_ff = 1'b0;

	// Reference stands low when stopped or while the oscillator starts
	always @(posedge clock) begin
		if (!ref_run || !osc_ready_pin) begin
			ref_cnt_ff <= 0;
			ref_ff <= 1'b0;
		end else if (ref_cnt_ff >= REF_HALF - 1) begin
			ref_cnt_ff <= 0;
			ref_ff <= ~ref_ff;
		end else begin
			ref_cnt_ff <= ref_cnt_ff + 1;
		end
	end

	// Feedback rate sets the ratio the lock detector measures
	always @(posedge clock) begin
		if (fb_cnt_ff >= int'(fb_half) - 1) begin
			fb_cnt_ff <= 0;
			fb_ff <= ~fb_ff;
		end else begin
			fb_cnt_ff <= fb_cnt_ff + 1;
		end
	end

	// Oscillator is ready only some cycles after being switched on
	always @(posedge clock) begin
		if (!osc_on) begin
			osc_cnt_ff <= 0;
		end else if (osc_cnt_ff < OSC_START) begin
			osc_cnt_ff <= osc_cnt_ff + 1;
		end
	end

	assign ref_clk_pin = ref_ff;
	assign pll_fb_pin = fb_ff;
	assign osc_ready_pin = osc_cnt_ff >= OSC_START;
endmodule : pllcls_ref_model

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench
	import pllcls_pkg::*;
;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] reg_addr = 24'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic stop_req = 1'b0;
	logic ref_run = 1'b1;
	logic osc_on = 1'b1;
	logic [2:0] strap = 3'h7;
	logic [7:0] fb_half = 8'h06;
	logic [31:0] reg_rdata;
	logic [31:0] rdat;
	logic ref_clk_pin, pll_fb_pin, osc_ready_pin;
	logic sys_reset_n_out, lock_flag, self_clocked_mode;
	logic [3:0] sys_mult, sys_div_shift;
	logic [2:0] modes [4] = '{3'h4, 3'h0, 3'h6, 3'h7};
	logic [7:0] ratios [4] = '{8'h10, 8'h11, 8'h41, 8'h41};
	int error_cnt = 0;
	int cmp_count = 0;

	// ------------------------------------------------------------
	// Clock, partner and device
	// ------------------------------------------------------------
	initial begin
		forever #2 clock = ~clock;
	end

	pllcls_ref_model u_ref (
		.clock(clock), .ref_run(ref_run), .fb_half(fb_half),
		.osc_on(osc_on), .ref_clk_pin(ref_clk_pin),
		.pll_fb_pin(pll_fb_pin), .osc_ready_pin(osc_ready_pin)
	);

	// Short window keeps the run brief; loss span exceeds ref period 48
	pllcls_status #(.WINDOW(8), .LOSS_CYCLES(100)) uut (
		.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ref_clk_pin(ref_clk_pin),
		.pll_fb_pin(pll_fb_pin), .osc_ready_pin(osc_ready_pin),
		.pll_enable_strap(strap[2]), .pll_ratio_strap(strap[1]),
		.pll_ref_strap(strap[0]), .stop_req(stop_req),
		.sys_reset_n_out(sys_reset_n_out), .lock_flag(lock_flag),
		.self_clocked_mode(self_clocked_mode), .sys_mult(sys_mult),
		.sys_div_shift(sys_div_shift)
	);

	// ------------------------------------------------------------
	// Bus and check tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [23:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [23:0] a, output logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		d = reg_rdata;
	endtask : rd

	// Bounded wait on lock (sel 0) or released reset (sel 1)
	task automatic wait_for(input logic sel, input logic v);
		logic s;
		for (int n = 0; n < 4000; n++) begin
			s = sel ? sys_reset_n_out : lock_flag;
			if (s === v) break;
			@(negedge clock);
		end
		chk({31'h0, s}, {31'h0, v});
	endtask : wait_for

	task automatic do_reset(input logic [2:0] m);
		@(posedge clock);
		rst_n <= 1'b0;
		strap <= m;
		ref_run <= m[2];
		fb_half <= m[1] ? 8'h06 : 8'h18;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		ref_run <= 1'b1;
		wait_for(1'b1, 1'b1);
	endtask : do_reset

	// Oscillator is switched off at stop entry when osc is low and left off after the stop
	task automatic do_stop(input logic [31:0] c, input logic osc);
		wr(CTRL_OFS, c);
		@(posedge clock);
		stop_req <= 1'b1;
		osc_on <= osc;
		repeat (40) @(posedge clock);
		stop_req <= 1'b0;
		repeat (8) @(posedge clock);
		rd(STAT_OFS, rdat);
	endtask : do_stop

	task automatic ref_gap;
		@(posedge clock);
		ref_run <= 1'b0;
		repeat (300) @(posedge clock);
		ref_run <= 1'b1;
		repeat (100) @(posedge clock);
		rd(STAT_OFS, rdat);
	endtask : ref_gap

	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		for (int i = 0; i < 4; i++) begin
			do_reset(modes[i]);
			chk({24'h0, sys_mult, sys_div_shift}, {24'h0, ratios[i]});
			rd(STAT_OFS, rdat);
			chk(rdat, {24'h0, modes[i], {2{modes[i][2]}}, 3'h0});
			if (modes[i] == 3'h0) begin
				wr(CTRL_OFS, 32'h2180);
				ref_gap();
				chk(rdat, 32'h0);
			end
		end
		rd(TEST2_OFS, rdat);
		chk(rdat, 32'h0);
		wr(TEST_OFS, 32'hff);
		wr(TEST2_OFS, 32'hffff_ffff);
		rd(TEST_OFS, rdat);
		chk(rdat, 32'h0);
		rd(TEST2_OFS, rdat);
		chk(rdat, 32'h3ff);
		wr(TEST2_OFS, 32'h155);
		rd(TEST2_OFS, rdat);
		chk(rdat, 32'h155);
		rd(24'hc3_0008, rdat);
		chk(rdat, 32'h0);
		// Strap moved after release must not change the latched mode
		@(posedge clock);
		strap <= 3'h0;
		rd(STAT_OFS, rdat);
		chk(rdat, 32'hf8);
		@(posedge clock);
		strap <= 3'h7;
		repeat (8) @(posedge clock);
		// Stop with the loop running keeps both lock flags
		do_stop(32'h2124, 1'b1);
		chk({30'h0, rdat[ST_STICKY_LOCK_FLAG_BIT], lock_flag}, 32'h3);
		// Stop with the loop off, plain and with fast wakeup
		do_stop(32'h2108, 1'b1);
		chk({31'h0, rdat[ST_STICKY_LOCK_FLAG_BIT]}, 32'h1);
		wait_for(1'b0, 1'b1);
		do_stop(32'h2128, 1'b1);
		chk({31'h0, rdat[ST_STICKY_LOCK_FLAG_BIT]}, 32'h0);
		wait_for(1'b0, 1'b1);
		rd(STAT_OFS, rdat);
		chk({31'h0, rdat[ST_STICKY_LOCK_FLAG_BIT]}, 32'h1);
		do_stop(32'h212c, 1'b0);
		chk({30'h0, self_clocked_mode, rdat[ST_STICKY_CLOCK_LOSS_FLAG_BIT]}, 32'h3);
		@(posedge clock);
		osc_on <= 1'b1;
		repeat (60) @(posedge clock);
		rd(STAT_OFS, rdat);
		chk({30'h0, self_clocked_mode, rdat[ST_STICKY_CLOCK_LOSS_FLAG_BIT]}, 32'h0);
		wait_for(1'b0, 1'b1);
		// Frequency error drops lock; sticky stays clear after relock
		@(posedge clock);
		fb_half <= 8'h07;
		wait_for(1'b0, 1'b0);
		@(posedge clock);
		fb_half <= 8'h06;
		wait_for(1'b0, 1'b1);
		rd(STAT_OFS, rdat);
		chk(rdat, 32'he8);
		// Multiplier change: new ratio, sticky set again on relock
		wr(CTRL_OFS, 32'h4300);
		@(posedge clock);
		fb_half <= 8'h04;
		repeat (3) @(negedge clock);
		chk({24'h0, sys_mult, sys_div_shift}, 32'h63);
		wait_for(1'b0, 1'b1);
		rd(STAT_OFS, rdat);
		chk(rdat, 32'hf8);
		// Reference loss with detection off, then on
		ref_gap();
		chk({30'h0, self_clocked_mode, rdat[ST_STICKY_CLOCK_LOSS_FLAG_BIT]}, 32'h0);
		wait_for(1'b0, 1'b1);
		wr(CTRL_OFS, 32'h4380);
		ref_gap();
		chk({30'h0, self_clocked_mode, rdat[ST_STICKY_CLOCK_LOSS_FLAG_BIT]}, 32'h3);
		report_and_stop();
	end

	// Hang guard, well beyond the expected run length
	initial begin
		repeat (60000) @(posedge clock);
		error_cnt++;
		report_and_stop();
	end
endmodule : testbench
